/* File: logic/drs_debug_run_status.sv */
// Debug run control and read-only run status register with interrupt.
`timescale 1ns/1ps
module drs_debug_run_status import drs_pkg::*; (
	// Clock, reset and enable.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// Register port.
	input wire logic [1:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rd_data,
	// Capture events from the comparators and the trace FIFO.
	input wire logic i_match_a,
	input wire logic i_match_b,
	input wire logic i_trigger,
	input wire logic i_capture,
	input wire logic i_fifo_read,
	// Run state and interrupt.
	output logic o_run_active,
	output logic o_irq
);

	// ****************************************
	// State and decode
	// ****************************************
	drs_state_t s_q;
	drs_state_t s_d;
	logic [3:0] cnt_w;
	logic full_w;
	logic start_w;
	logic running_w;

	// Decodes a register strobe at one address.
	function automatic logic hit(input logic strobe, input logic [1:0] addr,
		input logic [1:0] target);
		hit = strobe && (addr == target);
	endfunction

	// Builds the status byte from flags and count; bit four stays zero.
	function automatic logic [7:0] status_byte(input drs_state_t s, input logic [3:0] cnt);
		logic [7:0] b;
		b = 8'h00;
		b[STAT_MATCH_A_BIT] = s.match_a;
		b[STAT_MATCH_B_BIT] = s.match_b;
		b[STAT_RUN_BIT] = (s.st == ST_RUN) && s.en;
		b[STAT_SPARE_BIT] = 1'b0;
		b[STAT_CNT_LSB +: CNT_W] = cnt;
		status_byte = b;
	endfunction

	assign running_w = (s_q.st == ST_RUN);
	// A run starts when the request and enable are both written to 1 from idle.
	assign start_w = !running_w && hit(i_wr, i_addr, ADDR_CTRL) &&
		i_wr_data[CTRL_EN_BIT] && i_wr_data[CTRL_ARM_BIT];

	// ****************************************
	// Valid word counter
	// ****************************************
	// Only captures during a run count; FIFO reads do not reach the counter.
	drs_word_counter u_cnt (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_clk_en(i_clk_en),
		.i_clear(start_w),
		.i_inc(running_w && i_capture),
		.o_cnt(cnt_w),
		.o_full(full_w)
	);

	// ****************************************
	// Next state
	// ****************************************
	// Run control, flags, register reads and interrupt bits.
	always_comb begin
		logic [2:0] ev;
		logic run_end;
		ev = 3'h0;
		run_end = 1'b0;
		s_d = s_q;
		s_d.rd_data = RD_DATA_RST;

		// Control writes; the status address takes no write at all.
		if (hit(i_wr, i_addr, ADDR_CTRL)) begin
			s_d.en = i_wr_data[CTRL_EN_BIT];
			s_d.trace_end = i_wr_data[CTRL_MODE_BIT];
			if (start_w) begin
				s_d.st = ST_RUN;
				s_d.match_a = 1'b0;
				s_d.match_b = 1'b0;
			end else if (running_w &&
				!(i_wr_data[CTRL_EN_BIT] && i_wr_data[CTRL_ARM_BIT])) begin
				run_end = 1'b1;
			end
		end
		if (hit(i_wr, i_addr, ADDR_IRQ_MASK)) begin
			s_d.irq_mask = i_wr_data[IRQ_W-1:0];
		end

		// Comparator flags record matches seen while armed.
		if (running_w && i_match_a) begin
			s_d.match_a = 1'b1;
			ev[IRQ_MATCH_A_BIT] = 1'b1;
		end
		if (running_w && i_match_b) begin
			s_d.match_b = 1'b1;
			ev[IRQ_MATCH_B_BIT] = 1'b1;
		end

		// Automatic end: FIFO full in begin trace, trigger in end trace.
		if (running_w && !s_q.trace_end && full_w) begin
			run_end = 1'b1;
		end
		if (running_w && s_q.trace_end && i_trigger) begin
			run_end = 1'b1;
		end
		if (run_end) begin
			s_d.st = ST_IDLE;
			ev[IRQ_RUN_END_BIT] = 1'b1;
		end

		// Read data stand in the cycle after the read strobe only.
		if (i_rd) begin
			unique case (i_addr)
				ADDR_CTRL: begin
					s_d.rd_data[CTRL_EN_BIT] = s_q.en;
					s_d.rd_data[CTRL_ARM_BIT] = running_w;
					s_d.rd_data[CTRL_MODE_BIT] = s_q.trace_end;
				end
				ADDR_STATUS: begin
					s_d.rd_data = status_byte(s_q, cnt_w);
				end
				ADDR_IRQ_STAT: begin
					s_d.rd_data[IRQ_W-1:0] = s_q.irq_stat;
				end
				ADDR_IRQ_MASK: begin
					s_d.rd_data[IRQ_W-1:0] = s_q.irq_mask;
				end
			endcase
		end

		// Sticky events; a read clears them but a same-cycle event survives.
		if (hit(i_rd, i_addr, ADDR_IRQ_STAT)) begin
			s_d.irq_stat = ev;
		end else begin
			s_d.irq_stat = s_q.irq_stat | ev;
		end
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
		s_d.run_active = (s_d.st == ST_RUN) && s_d.en;
	end

	// ****************************************
	// State register
	// ****************************************
	// All fields reset to zero; the clock enable freezes everything.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '{st: ST_IDLE, en: 1'b0, trace_end: 1'b0, match_a: 1'b0,
				match_b: 1'b0, irq_stat: IRQ_RST, irq_mask: IRQ_RST,
				rd_data: RD_DATA_RST, irq: 1'b0, run_active: 1'b0};
		end else if (i_clk_en) begin
			s_q <= s_d;
		end
	end

	assign o_rd_data = s_q.rd_data;
	assign o_irq = s_q.irq;
	assign o_run_active = s_q.run_active;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	// A write to the status address with no events changes no status field.
	// A full FIFO in begin trace may end the run on its own, so that cycle is left out.
	AST_STATUS_RO: assert property ((i_clk_en && hit(i_wr, i_addr, ADDR_STATUS) &&
		!i_match_a && !i_match_b && !i_trigger && !i_capture && !i_rd &&
		!(running_w && !s_q.trace_end && full_w))
		|=> ($stable(s_q.match_a) && $stable(s_q.match_b) && $stable(s_q.st) &&
		$stable(cnt_w)))
		else $error("Status register changed on a write.");

	// A comparator A match during a run sets its flag.
	AST_MATCH_A: assert property ((i_clk_en && running_w && i_match_a)
		|=> s_q.match_a)
		else $error("Match A flag not set after match.");

	// A comparator B match during a run sets its flag.
	AST_MATCH_B: assert property ((i_clk_en && running_w && i_match_b)
		|=> s_q.match_b)
		else $error("Match B flag not set after match.");

	// Status read shows the run bit that held at the read.
	AST_RUN_MIRROR: assert property ((i_clk_en && hit(i_rd, i_addr, ADDR_STATUS))
		|=> (o_rd_data[STAT_RUN_BIT] == $past(running_w && s_q.en)))
		else $error("Status run bit does not mirror run request.");

	// Arming from idle starts a run that shows on the run output.
	AST_ARM_START: assert property ((i_clk_en && start_w)
		|=> (running_w && o_run_active && !s_q.match_a && !s_q.match_b))
		else $error("Run did not start on arm write.");

	// A full FIFO in begin trace ends the run one cycle later.
	AST_AUTO_END: assert property ((i_clk_en && running_w && !s_q.trace_end && full_w)
		|=> (!running_w && !o_run_active))
		else $error("Run not ended on full FIFO.");

	// A trigger in end trace ends the run one cycle later.
	AST_TRIG_END: assert property ((i_clk_en && running_w && s_q.trace_end && i_trigger)
		|=> !running_w)
		else $error("Run not ended on trigger.");

	// Writing request or enable low ends a run.
	AST_MANUAL_END: assert property ((i_clk_en && running_w && hit(i_wr, i_addr, ADDR_CTRL) &&
		!(i_wr_data[CTRL_EN_BIT] && i_wr_data[CTRL_ARM_BIT])) |=> (!running_w && !o_run_active))
		else $error("Run not ended by manual write.");

	// The count is zero right after a start and no more than the FIFO depth one cycle later.
	AST_CNT_START: assert property ((i_clk_en && start_w)
		|=> ((cnt_w == CNT_RST) ##1 (cnt_w <= FIFO_DEPTH)))
		else $error("Valid count not cleared at run start.");

	// Outside a run, FIFO reads leave the count alone.
	AST_CNT_HOLD: assert property ((!running_w && !start_w && i_fifo_read)
		|=> $stable(cnt_w))
		else $error("Valid count changed on FIFO read.");

	// The spare status bit always reads zero.
	AST_SPARE_ZERO: assert property (hit(i_rd, i_addr, ADDR_STATUS) && i_clk_en
		|=> (o_rd_data[STAT_SPARE_BIT] == 1'b0))
		else $error("Spare status bit read as one.");

	// Main scenarios.
	COV_START: cover property (i_clk_en && start_w);
	COV_FULL_END: cover property (running_w && !s_q.trace_end && full_w && i_clk_en);
	COV_TRIG_END: cover property (running_w && s_q.trace_end && i_trigger && i_clk_en);
	COV_IRQ: cover property (o_irq ##1 !o_irq);

endmodule

/* File: shared/drs_pkg.sv */
// Package of constants and types for the debug run status block.
package drs_pkg;

	// ****************************************
	// Register map and register bus widths
	// ****************************************
	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam logic [1:0] ADDR_CTRL = 2'h0;
	localparam logic [1:0] ADDR_STATUS = 2'h1;
	localparam logic [1:0] ADDR_IRQ_STAT = 2'h2;
	localparam logic [1:0] ADDR_IRQ_MASK = 2'h3;

	// ****************************************
	// Control register field positions
	// ****************************************
	localparam int CTRL_EN_BIT = 0;
	localparam int CTRL_ARM_BIT = 1;
	localparam int CTRL_MODE_BIT = 2;

	// ****************************************
	// Status register field positions
	// ****************************************
	localparam int STAT_MATCH_A_BIT = 7;
	localparam int STAT_MATCH_B_BIT = 6;
	localparam int STAT_RUN_BIT = 5;
	localparam int STAT_SPARE_BIT = 4;
	localparam int STAT_CNT_LSB = 0;
	localparam int CNT_W = 4;

	// ****************************************
	// Interrupt status and mask bit positions
	// ****************************************
	localparam int IRQ_W = 3;
	localparam int IRQ_RUN_END_BIT = 0;
	localparam int IRQ_MATCH_A_BIT = 1;
	localparam int IRQ_MATCH_B_BIT = 2;

	// ****************************************
	// Reset values and counts
	// ****************************************
	localparam logic [7:0] RD_DATA_RST = 8'h00;
	localparam logic [2:0] IRQ_RST = 3'h0;
	localparam logic [3:0] CNT_RST = 4'h0;
	localparam logic [3:0] FIFO_DEPTH = 4'h8;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN = 1'b1
	} drs_run_state_t;

	typedef struct packed {
		drs_run_state_t st;
		logic en;
		logic trace_end;
		logic match_a;
		logic match_b;
		logic [2:0] irq_stat;
		logic [2:0] irq_mask;
		logic [7:0] rd_data;
		logic irq;
		logic run_active;
	} drs_state_t;

	typedef struct packed {
		logic [3:0] cnt;
	} drs_cnt_state_t;

endpackage

/* File: logic/drs_word_counter.sv */
// Saturating count of valid trace words captured during a debug run.
`timescale 1ns/1ps
module drs_word_counter import drs_pkg::*; (
	// Clock, reset and enable.
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// Count control.
	input wire logic i_clear,
	input wire logic i_inc,
	// Count result.
	output logic [3:0] o_cnt,
	output logic o_full
);

	drs_cnt_state_t s_q;
	drs_cnt_state_t s_d;

	// Clear has priority; increments stop once the FIFO depth is reached.
	always_comb begin
		s_d = s_q;
		if (i_clear) begin
			s_d.cnt = CNT_RST;
		end else if (i_inc && (s_q.cnt != FIFO_DEPTH)) begin
			s_d.cnt = s_q.cnt + 4'h1;
		end
	end

	// State register, frozen while the clock enable is low.
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			s_q <= '{cnt: CNT_RST};
		end else if (i_clk_en) begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the count register.
	assign o_cnt = s_q.cnt;
	assign o_full = (s_q.cnt == FIFO_DEPTH);

endmodule

/* File: sim/drs_host_model.sv */
// Debug host model that drives the register port and reads out the trace buffer.
`timescale 1ns/1ps
module drs_host_model import drs_pkg::*; (
	// Clock.
	input wire logic i_sys_clk,
	// Register port and trace read-out strobe.
	output logic [1:0] o_addr,
	output logic [7:0] o_wr_data,
	output logic o_wr,
	output logic o_rd,
	output logic o_fifo_read,
	input wire logic [7:0] i_rd_data
);
	// Words that the host still expects to read from the trace buffer.
	int remaining;

	// All strobes start low.
	initial begin
		o_addr = 2'h0;
		o_wr_data = 8'h00;
		o_wr = 1'b0;
		o_rd = 1'b0;
		o_fifo_read = 1'b0;
	end

	// One-cycle write strobe; data is inverted once released so stale data cannot help.
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wr_data <= d;
		o_wr <= 1'b1;
		@(posedge i_sys_clk);
		o_wr <= 1'b0;
		o_wr_data <= ~d;
	endtask

	// One-cycle read strobe; the data stand only in the following cycle.
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd <= 1'b1;
		@(posedge i_sys_clk);
		o_rd <= 1'b0;
		#1;
		d = i_rd_data;
	endtask

	// Reads out the captured words, counting down its own tally.
	task automatic drain(input int n);
		remaining = n;
		while (remaining > 0) begin
			@(posedge i_sys_clk);
			o_fifo_read <= 1'b1;
			remaining--;
		end
		@(posedge i_sys_clk);
		o_fifo_read <= 1'b0;
	endtask
endmodule

/* File: sim/drs_debug_run_status_tb_top.sv */
// Self-checking testbench of the debug run status block.
`timescale 1ns/1ps
module drs_debug_run_status_tb_top import drs_pkg::*;;
	logic sys_clk, rst, match_a, match_b, trig, cap, wr, rd, fifo_read, run_active, irq;
	logic [1:0] addr;
	logic [7:0] wr_data, rd_data, d;
	logic exp_a, exp_b, exp_run, ce;
	int num_errors, n_compared, seed, n_cap, exp_cnt, exp_irq, exp_mask;

	// Host on the register side.
	drs_host_model host (.i_sys_clk(sys_clk), .o_addr(addr), .o_wr_data(wr_data), .o_wr(wr),
		.o_rd(rd), .o_fifo_read(fifo_read), .i_rd_data(rd_data));

	// Block under test; the clock enable is held on except for one low cycle in each run.
	drs_debug_run_status dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_clk_en(ce), .i_addr(addr),
		.i_wr_data(wr_data), .i_wr(wr), .i_rd(rd), .o_rd_data(rd_data), .i_match_a(match_a),
		.i_match_b(match_b), .i_trigger(trig), .i_capture(cap), .i_fifo_read(fifo_read),
		.o_run_active(run_active), .o_irq(irq));

	// Pseudo-random sequence for capture counts and junk write data.
	function automatic int lfsr(input int x);
		return int'({x[15:0], x[16] ^ x[13]});
	endfunction

	// Compares one value and counts it.
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	// Pulses one event for a cycle: 0 match A, 1 match B, 2 trigger, 3 capture.
	task automatic ev(input int k, input logic mode);
		@(posedge sys_clk);
		{match_a, match_b, trig, cap} <= 4'(8 >> k);
		@(posedge sys_clk);
		{match_a, match_b, trig, cap} <= 4'h0;
		if (exp_run) begin
			if (k < 2) exp_irq |= 2 << k;
			if (k == 0) exp_a = 1'b1;
			if (k == 1) exp_b = 1'b1;
			if (k == 3 && exp_cnt < 8) exp_cnt++;
			if ((k == 3 && !mode && exp_cnt == 8) || (k == 2 && mode)) begin
				exp_run = 1'b0;
				exp_irq |= 1;
			end
		end
	endtask

	// Reads the status register and compares it and the run output with the model.
	task automatic chk_stat();
		host.rd(ADDR_STATUS, d);
		check(d, {exp_a, exp_b, exp_run, 1'b0, 4'(exp_cnt)}, "status");
		check({7'h00, run_active}, {7'h00, exp_run}, "run active");
	endtask

	// Checks the interrupt level, then reads and clears the event status.
	task automatic chk_irq();
		check({7'h00, irq}, {7'h00, |(exp_irq & exp_mask)}, "irq level");
		host.rd(ADDR_IRQ_STAT, d);
		check(d, 8'(exp_irq), "irq status");
		exp_irq = 0;
		@(posedge sys_clk);
		#1;
		check({7'h00, irq}, 8'h00, "irq after clear");
	endtask

	// Prints the verdict and ends the run.
	task automatic final_report();
		if (num_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// Clock of 25 ns.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// Cuts a hang short.
	initial begin
		repeat (5000) @(posedge sys_clk);
		num_errors++;
		final_report();
	end

	// Six runs over both trace modes and the automatic and manual ends.
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		{match_a, match_b, trig, cap} = 4'h0;
		{exp_a, exp_b, exp_run} = 3'h0;
		{num_errors, n_compared, exp_cnt, exp_irq, exp_mask} = '0;
		seed = 82984;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		chk_stat();
		for (int r = 0; r < 6; r++) begin
			exp_mask = (r == 0) ? 0 : 7;
			host.wr(ADDR_IRQ_MASK, 8'(exp_mask));
			host.rd(ADDR_IRQ_MASK, d);
			check(d, 8'(exp_mask), "mask");
			host.wr(ADDR_CTRL, {5'h00, r[0], 2'b11});
			{exp_a, exp_b, exp_run} = 3'h1;
			exp_cnt = 0;
			chk_stat();
			// A capture while the clock enable is low must leave the count alone.
			@(posedge sys_clk);
			ce <= 1'b0;
			cap <= 1'b1;
			@(posedge sys_clk);
			ce <= 1'b1;
			cap <= 1'b0;
			seed = lfsr(seed);
			if (seed[0]) ev(0, r[0]);
			if (seed[1]) ev(1, r[0]);
			if (!r[0]) ev(2, 1'b0);
			n_cap = (r % 3 == 0 && !r[0]) ? 9 : seed[4:2];
			repeat (n_cap) ev(3, r[0]);
			if (r % 3 == 0 && r[0]) ev(2, 1'b1);
			if (r % 3 != 0) begin
				host.wr(ADDR_CTRL, {5'h00, r[0], (r % 3 == 1) ? 2'b01 : 2'b10});
				exp_run = 1'b0;
				exp_irq |= 1;
			end
			chk_stat();
			host.drain(exp_cnt);
			host.wr(ADDR_STATUS, 8'(seed));
			chk_stat();
			chk_irq();
		end
		final_report();
	end
endmodule
